// [hdl/gwc_wakeup_ctrl.v]
// gwc_wakeup_ctrl.v: gpio wakeup controller, debounce and edge paths
// assumes clk is the sleep clock; control bits are plain ports
//
// How it works
// - clocked sleep: trigger synchronised, stable three sleep pulses before interrupt
// - clockless sleep: raw trigger level, registered on clk, requests clock restart
// - all 37 input lines can be monitored
// - per-line polarity select xors each line before detection
// - debounce time programmable from 0 to 63 ms
// - debounced lines are ored and fed to the debounce counter
// - counter loads value, decrements per ms, fires if still active
// - edge-selected lines latch active edges into sticky status bits
// - interrupt asserted while any edge status bit is set
// - enable bit off or edge select off masks the interrupt
// - acknowledge write clears the pending debounce interrupt, unless it fires in the same cycle
// - edge clear write clears selected status bits
// - edge path inactive without clock; only levels restart clock
// - interrupt goes to the wake interrupt controller
`timescale 1ns/1ps
`include "gwc_defs.vh"

module gwc_wakeup_ctrl #(
   parameter N          = `GWC_NUM_LINES,
   parameter DW         = `GWC_DEB_W,
   parameter TICK_CYC   = `GWC_TICK_CYCLES
) (
   input  wire          clk,
   input  wire          reset_n,
   input  wire [N-1:0]  gpio_in,
   input  wire [N-1:0]  line_polarity_select,
   input  wire [N-1:0]  debounced_line_select,
   input  wire [N-1:0]  edge_line_select,
   input  wire          irq_enable,
   input  wire [DW-1:0] debounce_reload,
   input  wire          clockless_sleep,
   input  wire          interrupt_acknowledge,
   input  wire          edge_pending_clear_we,
   input  wire [N-1:0]  edge_pending_clear,
   output reg  [N-1:0]  edge_pending_status,
   output reg           wake_line_interrupt,
   output reg           clock_restart_req
);

   // ----------------------------------------------------------------
   // polarity and filtering
   // ----------------------------------------------------------------
   wire [N-1:0] act_raw;
   wire [N-1:0] act_stable;

   assign act_raw = gpio_in ^ line_polarity_select;

   gwc_line_filter #(
      .N      (N),
      .STABLE (`GWC_STABLE_PULSES)
   ) u_filter (
      .clk         (clk),
      .reset_n     (reset_n),
      .line_in     (act_raw),
      .line_stable (act_stable)
   );

   // ----------------------------------------------------------------
   // millisecond tick
   // ----------------------------------------------------------------
   localparam PW = 20;
   reg  [PW-1:0] pre_r;
   reg           tick_r;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_r  <= {PW{1'b0}};
         tick_r <= 1'b0;
      end else if (pre_r == TICK_CYC - 1) begin
         pre_r  <= {PW{1'b0}};
         tick_r <= 1'b1;
      end else begin
         pre_r  <= pre_r + {{(PW-1){1'b0}}, 1'b1};
         tick_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // debounce path
   // ----------------------------------------------------------------
   localparam DS_IDLE = 2'd0;
   localparam DS_CNT  = 2'd1;
   localparam DS_WAIT = 2'd2;

   reg  [1:0]    ds_r;
   reg  [DW-1:0] deb_cnt_r;
   reg           deb_pend_r;
   wire          deb_or;
   wire          deb_fire;

   assign deb_or = |(act_stable & debounced_line_select);

   // fire at zero only while still active
   assign deb_fire = (ds_r == DS_CNT) & deb_or & (deb_cnt_r == {DW{1'b0}});

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ds_r       <= DS_IDLE;
         deb_cnt_r  <= {DW{1'b0}};
         deb_pend_r <= 1'b0;
      end else begin
         case (ds_r)
            DS_IDLE: begin
               if (deb_or) begin
                  deb_cnt_r <= debounce_reload;
                  ds_r      <= DS_CNT;
               end
            end
            DS_CNT: begin
               // decrement per ms, fire if still active
               if (!deb_or) begin
                  ds_r <= DS_IDLE;
               end else if (deb_cnt_r == {DW{1'b0}}) begin
                  ds_r <= DS_WAIT;
               end else if (tick_r) begin
                  deb_cnt_r <= deb_cnt_r - {{(DW-1){1'b0}}, 1'b1};
               end
            end
            DS_WAIT: begin
               // re-arm only once the buttons release
               if (!deb_or) begin
                  ds_r <= DS_IDLE;
               end
            end
            default: begin
               ds_r <= DS_IDLE;
            end
         endcase
         if (deb_fire) begin
            deb_pend_r <= 1'b1;
         end else if (interrupt_acknowledge) begin
            deb_pend_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // edge capture path
   // ----------------------------------------------------------------
   reg  [N-1:0] prev_r;
   wire [N-1:0] rise;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_r <= {N{1'b0}};
      end else begin
         prev_r <= act_stable;
      end
   end

   // active edge only; reprogramming polarity can itself look like one
   assign rise = act_stable & ~prev_r & edge_line_select;

   // ----------------------------------------------------------------
   // edge status
   // ----------------------------------------------------------------
   wire [N-1:0] edge_pending_status_nxt;

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_edge
         assign edge_pending_status_nxt[g] = rise[g] |
            (edge_pending_status[g] & ~(edge_pending_clear_we & edge_pending_clear[g]));
      end
   endgenerate

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         edge_pending_status <= {N{1'b0}};
      end else begin
         edge_pending_status <= edge_pending_status_nxt;
      end
   end

   // ----------------------------------------------------------------
   // wake interrupt
   // ----------------------------------------------------------------
   wire edge_any;
   wire irq_src;

   assign edge_any = |(edge_pending_status & edge_line_select);
   assign irq_src  = deb_pend_r | edge_any;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wake_line_interrupt <= 1'b0;
      end else begin
         wake_line_interrupt <= irq_enable & irq_src;
      end
   end

   // ----------------------------------------------------------------
   // clock restart
   // ----------------------------------------------------------------
   wire restart_src;

   // raw level: no clock to run the filter
   assign restart_src = |(act_raw & (debounced_line_select | edge_line_select));

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clock_restart_req <= 1'b0;
      end else begin
         clock_restart_req <= clockless_sleep & restart_src;
      end
   end

endmodule // gwc_wakeup_ctrl

// [common/gwc_defs.vh]
// gwc_defs.vh: constants for the gpio wakeup controller
// assumes a 100 MHz clock driving the controller logic
`ifndef GWC_DEFS_VH
`define GWC_DEFS_VH

`define GWC_NUM_LINES     37
`define GWC_DEB_W         6
`define GWC_DEB_MAX_MS    63
`define GWC_STABLE_PULSES 3
`define GWC_CLK_NS        10
`define GWC_TICK_NS       1000000
`define GWC_TICK_CYCLES   (`GWC_TICK_NS / `GWC_CLK_NS)
`define GWC_EDGE_MIN_XTAL_US 60
`define GWC_EDGE_MIN_RC_US   180

`endif

// [hdl/gwc_line_filter.v]
// gwc_line_filter.v: per-line synchroniser and stability filter
// assumes line inputs change asynchronously relative to clk
`timescale 1ns/1ps
`include "gwc_defs.vh"

module gwc_line_filter #(
   parameter N      = `GWC_NUM_LINES,
   parameter STABLE = `GWC_STABLE_PULSES
) (
   input  wire         clk,
   input  wire         reset_n,
   input  wire [N-1:0] line_in,
   output wire [N-1:0] line_stable
);

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_line
         reg       s1_r;
         reg       s2_r;
         reg [1:0] cnt_r;
         reg       out_r;
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
            end else begin
               s1_r <= line_in[g];
               s2_r <= s1_r;
            end
         end
         always @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               cnt_r <= 2'h0;
               out_r <= 1'b0;
            end else if (s2_r == out_r) begin
               cnt_r <= 2'h0;
            end else if (cnt_r == STABLE - 1) begin
               cnt_r <= 2'h0;
               out_r <= s2_r;
            end else begin
               cnt_r <= cnt_r + 2'h1;
            end
         end
         assign line_stable[g] = out_r;
      end
   endgenerate

endmodule // gwc_line_filter

// [tb/gwc_wake_sva.sv]
// checker: port properties of the wakeup controller
// assumes bind onto gwc_wakeup_ctrl, one clock domain
`timescale 1ns/1ps
module gwc_wake_sva #(parameter N = 37, parameter DW = 6) (
   input wire          clk,
   input wire          reset_n,
   input wire [N-1:0]  gpio_in,
   input wire [N-1:0]  line_polarity_select,
   input wire [N-1:0]  debounced_line_select,
   input wire [N-1:0]  edge_line_select,
   input wire          irq_enable,
   input wire [DW-1:0] debounce_reload,
   input wire          clockless_sleep,
   input wire          interrupt_acknowledge,
   input wire          edge_pending_clear_we,
   input wire [N-1:0]  edge_pending_clear,
   input wire [N-1:0]  edge_pending_status,
   input wire          wake_line_interrupt,
   input wire          clock_restart_req
);
   // ----------
   // properties
   // ----------
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   mask_off_a: assert property (!irq_enable |=> !wake_line_interrupt)
      else $error("irq while disabled");
   status_irq_a: assert property (irq_enable && |(edge_pending_status & edge_line_select)
      |=> wake_line_interrupt) else $error("status without irq");
   sel_only_a: assert property ((edge_pending_status & ~$past(edge_pending_status)
      & ~$past(edge_line_select)) == '0) else $error("unselected capture");
   status_sticky_a: assert property (!$past(edge_pending_clear_we) |->
      (edge_pending_status & $past(edge_pending_status)) == $past(edge_pending_status))
      else $error("status dropped");
   clr_all_a: assert property (edge_pending_clear_we && &edge_pending_clear
      && edge_line_select == '0 |=> edge_pending_status == '0) else $error("clear failed");
   restart_on_a: assert property (clockless_sleep && |((gpio_in ^ line_polarity_select)
      & (debounced_line_select | edge_line_select)) |=> clock_restart_req)
      else $error("no restart");
   restart_off_a: assert property (!clockless_sleep |=> !clock_restart_req)
      else $error("restart while clocked");
   stable_in_a: assert property ($rose(edge_pending_status[0]) |->
      $past(gpio_in[0], 5) ^ $past(line_polarity_select[0], 5))
      else $error("unstable capture");
   ack_clr_a: assert property (interrupt_acknowledge && edge_pending_status == '0
      && debounced_line_select == '0 && edge_line_select == '0 |-> ##2 !wake_line_interrupt)
      else $error("ack ignored");
endmodule // gwc_wake_sva
bind gwc_wakeup_ctrl gwc_wake_sva #(.N(N), .DW(DW)) gwc_wake_sva_inst (
   .clk                   (clk),
   .reset_n               (reset_n),
   .gpio_in               (gpio_in),
   .line_polarity_select  (line_polarity_select),
   .debounced_line_select (debounced_line_select),
   .edge_line_select      (edge_line_select),
   .irq_enable            (irq_enable),
   .debounce_reload       (debounce_reload),
   .clockless_sleep       (clockless_sleep),
   .interrupt_acknowledge (interrupt_acknowledge),
   .edge_pending_clear_we (edge_pending_clear_we),
   .edge_pending_clear    (edge_pending_clear),
   .edge_pending_status   (edge_pending_status),
   .wake_line_interrupt   (wake_line_interrupt),
   .clock_restart_req     (clock_restart_req)
);

// [tb/gwc_line_model.sv]
// line model: buttons and sensors on the wakeup inputs
// assumes the bench gives target levels on press
`timescale 1ns/1ps
module gwc_line_model #(parameter N = 37, parameter HOLD = 8) (
   input  wire         clk,
   input  wire [N-1:0] press,
   output reg  [N-1:0] gpio_in
);
   int hold_r = 0;
   initial gpio_in = '0;
   always @(posedge clk) begin
      if (hold_r > 0) hold_r <= hold_r - 1;
      else if (press !== gpio_in) begin
         gpio_in <= press;
         hold_r  <= HOLD;
      end
   end
endmodule // gwc_line_model

// [tb/gwc_wakeup_ctrl_tb.sv]
// bench: edge, debounce and early-release wake scenarios
// assumes ms tick shortened to 10 clock cycles
`timescale 1ns/1ps
`include "gwc_defs.vh"
module gwc_wakeup_ctrl_tb;
   localparam N  = `GWC_NUM_LINES;
   localparam TK = 10;
   typedef struct {logic [N-1:0] st; int lo; int hi;} gwc_note_t;
   reg          clk = 1'b0, reset_n = 1'b0, ien = 1'b0, sl = 1'b0, ack = 1'b0, cwe = 1'b0;
   reg  [N-1:0] pol = '0, dsel = '0, esel = '0, press = '0, clr = '0;
   reg  [5:0]   rl = 6'h00;
   reg          irq_d = 1'b0;
   wire [N-1:0] gpio, st;
   wire         irq, rq;
   int          n_fail = 0, n_compared = 0, cyc = 0;
   gwc_note_t   q[$];
   always #5 clk = ~clk;
   gwc_line_model #(.N(N)) gwc_line_model_inst (.clk(clk), .press(press), .gpio_in(gpio));
   gwc_wakeup_ctrl #(.TICK_CYC(TK)) gwc_wakeup_ctrl_inst (.clk(clk), .reset_n(reset_n),
      .gpio_in(gpio), .line_polarity_select(pol), .debounced_line_select(dsel),
      .edge_line_select(esel), .irq_enable(ien), .debounce_reload(rl), .clockless_sleep(sl),
      .interrupt_acknowledge(ack), .edge_pending_clear_we(cwe), .edge_pending_clear(clr),
      .edge_pending_status(st), .wake_line_interrupt(irq), .clock_restart_req(rq));
   task automatic chk(input string nm, input logic [N-1:0] e, s);
      n_compared++;
      if (e !== s) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_of_test;
      if (q.size() != 0) chk("missed wakes", '0, N'(q.size()));
      if (n_fail == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [N-1:0] rnd();
      return N'({$urandom, $urandom});
   endfunction
   // -------
   // monitor
   // -------
   always @(posedge clk) begin
      gwc_note_t n;
      cyc <= cyc + 1;
      irq_d <= irq;
      if (irq === 1'b1 && irq_d !== 1'b1) begin
         if (q.size() == 0) chk("unexpected wake", '0, 1);
         else begin
            n = q.pop_front();
            chk("edge status", n.st, st);
            chk("wake time", 1, cyc >= n.lo && cyc <= n.hi);
         end
      end
   end
   // ---------
   // scenarios
   // ---------
   task automatic run(input logic [N-1:0] p, d, e, a, input int r, lo, hi, input bit c, early);
      @(posedge clk);
      {ien, pol, dsel, esel, rl, sl, press} <= {1'b0, p, d, e, r[5:0], c, p};
      repeat (20) @(posedge clk);
      {cwe, clr, ack} <= {1'b1, {N{1'b1}}, 1'b1};
      @(posedge clk);
      {cwe, ack, ien} <= 3'b001;
      repeat (2) @(posedge clk);
      if (!early) q.push_back('{e & a, cyc + lo, cyc + hi});
      press <= p ^ a;
      repeat (4) @(posedge clk);
      chk("restart request", N'(c && (a & (d | e)) != '0), N'(rq));
      repeat (early ? 11 : hi + 6) @(posedge clk);
      {dsel, esel, press} <= {{(2*N){1'b0}}, p};
      repeat (hi) @(posedge clk);
      chk("masked wake", N'(!early && d != '0), N'(irq));
      {cwe, ack} <= 2'b11;
      @(posedge clk);
      {cwe, ack} <= 2'b00;
      repeat (20) @(posedge clk);
      chk("cleared wake", '0, N'(irq));
      chk("cleared status", '0, st);
   endtask
   initial begin
      logic [N-1:0] w;
      int r;
      void'($urandom(37522));
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < N; i++) begin
         w = N'(1) << i;
         run(rnd(), '0, rnd() | w, rnd() | w, 0, 4, 14, $urandom % 2, 0);
      end
      for (int j = 0; j < 4; j++) begin
         r = j < 2 ? j : j == 2 ? 63 : $urandom_range(62, 2);
         w = N'(1) << $urandom_range(N - 1, 0);
         run(rnd(), rnd() | w, '0, w, r, r * TK - 10, r * TK + 16, 1, 0);
      end
      run(rnd(), w, '0, w, 20, 0, 200, 0, 1);
      end_of_test;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_of_test;
   end
endmodule // gwc_wakeup_ctrl_tb
